// file: cpu_interrupt_acceptance.v
// Purpose: interrupt acceptance, entry and return sequencing for the cpu core
// Assumes: all request pins synchronous to pclk; pipeline pulses take_window
// Notes:   registers over apb; return pc and state word go out as a redirect
//
// What this block does
// - equal level ties go to lowest source number
// - restartable instruction saves its own pc
// - illegal opcode saves offending pc plus four
// - non-maskable taken despite global disable
// - non-maskable request on rising pin edge
// - only highest simultaneous non-maskable is serviced
// - nmi0 during nmi0 waits for return
// - nmi1 during nmi0 waits unless busy cleared
// - nmi2 during nmi0 pre-empts at once
// - nmi entry saves, writes upper cause, vectors
// - return with busy set and ep clear restores nmi copies
// - sixty-four maskable sources, rising edge each
// - eight programmable levels per source
// - any acceptance sets global disable flag
// - nesting only by strictly higher level
// - maskable entry saves, writes lower cause, vectors
// - masked or blocked requests stay pending
// - return with flags clear restores maskable copies
// - source n vectors to 0x80 plus 16n
// - request flag clears on acceptance
// - mask flag one blocks, zero allows
// - level 0 highest through 7 lowest
`timescale 1ns/1ns
`include "cpu_irq_regs.vh"

module cpu_interrupt_acceptance #(
    parameter NUM_SRC = 64,
    parameter SRC_W   = 6,
    parameter LVL_W   = 3
) (
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [11:0]          paddr,
    input  wire [31:0]          pwdata,
    output wire [31:0]          prdata,
    output wire                 pready,
    output wire                 pslverr,
    input  wire [2:0]           nonmask_request_pin,
    input  wire [NUM_SRC-1:0]   maskable_request_pin,
    input  wire                 take_window,
    input  wire [31:0]          cur_pc,
    input  wire [31:0]          following_pc,
    input  wire                 restart_cur,
    input  wire                 illegal_op,
    input  wire                 return_from_handler,
    output wire                 redirect,
    output wire [31:0]          redirect_pc,
    output wire [31:0]          program_state_word
);

localparam NLVL = 1 << LVL_W;
////////////////////////////////////////////////////////////////////////////////
// state
reg  [NUM_SRC-1:0]        flag_ff;
reg  [NUM_SRC-1:0]        mask_ff;
reg  [NUM_SRC*LVL_W-1:0]  pri_ff;
reg  [NUM_SRC-1:0]        int_prev_ff;
reg  [2:0]                nmi_prev_ff;
reg  [2:0]                nmi_pend_ff;
reg  [1:0]                nmi_lvl_ff;
reg  [NLVL-1:0]           insvc_ff;
reg  [31:0]               psw_ff;
reg  [31:0]               irq_pc_ff;
reg  [31:0]               irq_st_ff;
reg  [31:0]               nmi_pc_ff;
reg  [31:0]               nmi_st_ff;
reg  [31:0]               cause_ff;
reg                       redirect_ff;
reg  [31:0]               redirect_pc_ff;
reg  [31:0]               prdata_ff;
reg                       pready_ff;
reg                       pslverr_ff;
reg  [NUM_SRC-1:0]        nxt_flag;
reg  [NUM_SRC-1:0]        nxt_mask;
reg  [NUM_SRC*LVL_W-1:0]  nxt_pri;
reg  [2:0]                nxt_nmi_pend;
reg  [1:0]                nxt_nmi_lvl;
reg  [NLVL-1:0]           nxt_insvc;
reg  [31:0]               nxt_psw;
reg  [31:0]               nxt_irq_pc;
reg  [31:0]               nxt_irq_st;
reg  [31:0]               nxt_nmi_pc;
reg  [31:0]               nxt_nmi_st;
reg  [31:0]               nxt_cause;
reg                       nxt_redirect;
reg  [31:0]               nxt_redirect_pc;
reg  [31:0]               nxt_prdata;
reg                       nxt_pslverr;

////////////////////////////////////////////////////////////////////////////////
// functions
// best eligible source: {valid, level, index}
function [LVL_W+SRC_W:0] pick_src;
    input [NUM_SRC-1:0]       req;
    input [NUM_SRC*LVL_W-1:0] pri;
    integer                   i;
    reg   [LVL_W+SRC_W:0]     best;
    begin
        best = {(LVL_W+SRC_W+1){1'b0}};
        // walk downward so the lowest number wins a level tie
        for (i = NUM_SRC - 1; i >= 0; i = i - 1)
        begin
            if (req[i] && (!best[LVL_W+SRC_W] || pri[i*LVL_W +: LVL_W] <= best[SRC_W +: LVL_W]))
                best = {1'b1, pri[i*LVL_W +: LVL_W], i[SRC_W-1:0]};
        end
        pick_src = best;
    end
endfunction

// lowest level number in service, NLVL when none
function [LVL_W:0] top_level;
    input [NLVL-1:0] vec;
    integer          i;
    reg   [LVL_W:0]  r;
    begin
        r = NLVL[LVL_W:0];
        for (i = NLVL - 1; i >= 0; i = i - 1)
        begin
            if (vec[i])
                r = i[LVL_W:0];
        end
        top_level = r;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// request detection and arbitration
wire [NUM_SRC-1:0]     int_edge  = maskable_request_pin & ~int_prev_ff;
wire [2:0]             nmi_edge  = nonmask_request_pin & ~nmi_prev_ff;
wire [NUM_SRC-1:0]     eligible  = flag_ff & ~mask_ff;
wire [LVL_W+SRC_W:0]   arb       = pick_src(eligible, pri_ff);
wire                   arb_ok    = arb[LVL_W+SRC_W];
wire [LVL_W-1:0]       arb_lvl   = arb[SRC_W +: LVL_W];
wire [SRC_W-1:0]       arb_idx   = arb[SRC_W-1:0];
wire [LVL_W:0]         ceiling   = top_level(insvc_ff);
wire                   np        = psw_ff[`PSW_NP];
wire                   id        = psw_ff[`PSW_ID];
wire                   ep        = psw_ff[`PSW_EP];
wire [31:0]            ret_pc    = restart_cur ? cur_pc : following_pc;
// non-maskable acceptance in service state
wire go2 = nmi_pend_ff[2] && (nmi_lvl_ff != `NL_NMI2);
wire go1 = nmi_pend_ff[1] && ((nmi_lvl_ff == `NL_NONE) ||
                              (nmi_lvl_ff == `NL_NMI0 && !np));
wire go0 = nmi_pend_ff[0] && (nmi_lvl_ff == `NL_NONE);
wire nmi_go = take_window && (go2 || go1 || go0);
// maskable acceptance: globally enabled and strictly above service level
wire irq_go = take_window && arb_ok && !id && !np &&
              ({1'b0, arb_lvl} < ceiling);
// apb phases
wire apb_setup = psel && !penable;
wire apb_wr    = psel && penable && pready_ff && pwrite && !pslverr_ff;
wire ctrl_hit  = (paddr[11:8] == `CTRL_PAGE);
wire [SRC_W-1:0] wr_idx = paddr[SRC_W+1:2];

////////////////////////////////////////////////////////////////////////////////
// next state
always @*
begin
    nxt_flag        = flag_ff;
    nxt_mask        = mask_ff;
    nxt_pri         = pri_ff;
    nxt_nmi_pend    = nmi_pend_ff;
    nxt_nmi_lvl     = nmi_lvl_ff;
    nxt_insvc       = insvc_ff;
    nxt_psw         = psw_ff;
    nxt_irq_pc      = irq_pc_ff;
    nxt_irq_st      = irq_st_ff;
    nxt_nmi_pc      = nmi_pc_ff;
    nxt_nmi_st      = nmi_st_ff;
    nxt_cause       = cause_ff;
    nxt_redirect    = 1'b0;
    nxt_redirect_pc = redirect_pc_ff;

    // software writes first; hardware below overrides them
    if (apb_wr)
    begin
        if (ctrl_hit)
        begin
            nxt_flag[wr_idx]                = pwdata[`CTL_FLAG];
            nxt_mask[wr_idx]                = pwdata[`CTL_MASK];
            nxt_pri[wr_idx*LVL_W +: LVL_W]  = pwdata[`CTL_PRI_HI:`CTL_PRI_LO];
        end
        else
        begin
            case (paddr)
                `A_PSW:    nxt_psw    = pwdata;
                `A_IRQ_PC: nxt_irq_pc = pwdata;
                `A_IRQ_ST: nxt_irq_st = pwdata;
                `A_NMI_PC: nxt_nmi_pc = pwdata;
                `A_NMI_ST: nxt_nmi_st = pwdata;
                default:   nxt_psw    = psw_ff;
            endcase
        end
    end

    if (illegal_op)
    begin
        // trap entry through the maskable copies
        nxt_irq_pc          = cur_pc + `ILG_PC_STEP;
        nxt_irq_st          = psw_ff;
        nxt_cause[15:0]     = `ILG_CODE;
        nxt_psw[`PSW_ID]    = 1'b1;
        nxt_psw[`PSW_EP]    = 1'b1;
        nxt_redirect        = 1'b1;
        nxt_redirect_pc     = {16'h0000, `ILG_CODE};
    end
    else if (return_from_handler)
    begin
        nxt_redirect = 1'b1;
        if (!ep && np)
        begin
            nxt_redirect_pc = nmi_pc_ff;
            nxt_psw         = nmi_st_ff;
            nxt_nmi_lvl     = `NL_NONE;
        end
        else
        begin
            nxt_redirect_pc = irq_pc_ff;
            nxt_psw         = irq_st_ff;
            if (!ep && ceiling != NLVL[LVL_W:0])
                nxt_insvc[ceiling[LVL_W-1:0]] = 1'b0;   // pop the top level in service
        end
    end
    else if (nmi_go)
    begin
        nxt_nmi_pc       = ret_pc;
        nxt_nmi_st       = psw_ff;
        nxt_psw[`PSW_NP] = 1'b1;
        nxt_psw[`PSW_ID] = 1'b1;
        nxt_psw[`PSW_EP] = 1'b0;
        nxt_redirect     = 1'b1;
        if (go2)
        begin
            nxt_cause[31:16] = `NMI2_CODE;
            nxt_nmi_lvl      = `NL_NMI2;
            nxt_nmi_pend     = 3'h0;
        end
        else if (go1)
        begin
            nxt_cause[31:16] = `NMI1_CODE;
            nxt_nmi_lvl      = `NL_NMI1;
            nxt_nmi_pend     = nmi_pend_ff & 3'h4;
        end
        else
        begin
            nxt_cause[31:16] = `NMI0_CODE;
            nxt_nmi_lvl      = `NL_NMI0;
            nxt_nmi_pend     = nmi_pend_ff & 3'h6;
        end
        nxt_redirect_pc = {16'h0000, nxt_cause[31:16]};
    end
    else if (irq_go)
    begin
        nxt_irq_pc       = ret_pc;
        nxt_irq_st       = psw_ff;
        nxt_cause[15:0]  = `IRQ_BASE + ({10'h000, arb_idx} << `IRQ_SHIFT);
        nxt_psw[`PSW_ID] = 1'b1;
        nxt_psw[`PSW_EP] = 1'b0;
        nxt_flag[arb_idx] = 1'b0;
        nxt_insvc[arb_lvl] = 1'b1;
        nxt_redirect     = 1'b1;
        nxt_redirect_pc  = {16'h0000, nxt_cause[15:0]};
    end

    // new edges win over any clear in the same cycle
    nxt_flag     = nxt_flag | int_edge;
    nxt_nmi_pend = nxt_nmi_pend | nmi_edge;
end

////////////////////////////////////////////////////////////////////////////////
// apb read data and error decode
always @*
begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (ctrl_hit)
    begin
        nxt_prdata[`CTL_FLAG]              = flag_ff[wr_idx];
        nxt_prdata[`CTL_MASK]              = mask_ff[wr_idx];
        nxt_prdata[`CTL_PRI_HI:`CTL_PRI_LO] = pri_ff[wr_idx*LVL_W +: LVL_W];
    end
    else
    begin
        case (paddr)
            `A_PSW:    nxt_prdata = psw_ff;
            `A_IRQ_PC: nxt_prdata = irq_pc_ff;
            `A_IRQ_ST: nxt_prdata = irq_st_ff;
            `A_NMI_PC: nxt_prdata = nmi_pc_ff;
            `A_NMI_ST: nxt_prdata = nmi_st_ff;
            `A_CAUSE:  nxt_prdata = cause_ff;
            `A_INSVC:  nxt_prdata = {{(32-NLVL){1'b0}}, insvc_ff};
            default:   nxt_pslverr = 1'b1;
        endcase
        if (pwrite && (paddr == `A_CAUSE || paddr == `A_INSVC))
            nxt_pslverr = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registers
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        flag_ff        <= {NUM_SRC{`CTL_RST_FLAG}};
        mask_ff        <= {NUM_SRC{`CTL_RST_MASK}};
        pri_ff         <= {NUM_SRC{`CTL_RST_PRI}};
        int_prev_ff    <= {NUM_SRC{1'b0}};
        nmi_prev_ff    <= 3'h0;
        nmi_pend_ff    <= 3'h0;
        nmi_lvl_ff     <= `NL_NONE;
        insvc_ff       <= {NLVL{1'b0}};
        psw_ff         <= `PSW_RST;
        irq_pc_ff      <= 32'h0000_0000;
        irq_st_ff      <= 32'h0000_0000;
        nmi_pc_ff      <= 32'h0000_0000;
        nmi_st_ff      <= 32'h0000_0000;
        cause_ff       <= 32'h0000_0000;
        redirect_ff    <= 1'b0;
        redirect_pc_ff <= 32'h0000_0000;
        prdata_ff      <= 32'h0000_0000;
        pready_ff      <= 1'b0;
        pslverr_ff     <= 1'b0;
    end
    else
    begin
        flag_ff        <= nxt_flag;
        mask_ff        <= nxt_mask;
        pri_ff         <= nxt_pri;
        int_prev_ff    <= maskable_request_pin;
        nmi_prev_ff    <= nonmask_request_pin;
        nmi_pend_ff    <= nxt_nmi_pend;
        nmi_lvl_ff     <= nxt_nmi_lvl;
        insvc_ff       <= nxt_insvc;
        psw_ff         <= nxt_psw;
        irq_pc_ff      <= nxt_irq_pc;
        irq_st_ff      <= nxt_irq_st;
        nmi_pc_ff      <= nxt_nmi_pc;
        nmi_st_ff      <= nxt_nmi_st;
        cause_ff       <= nxt_cause;
        redirect_ff    <= nxt_redirect;
        redirect_pc_ff <= nxt_redirect_pc;
        pready_ff      <= apb_setup;      // one wait-free access cycle
        if (apb_setup)
        begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end
end
// outputs straight from flops
assign prdata             = prdata_ff;
assign pready             = pready_ff;
assign pslverr            = pslverr_ff;
assign redirect           = redirect_ff;
assign redirect_pc        = redirect_pc_ff;
assign program_state_word = psw_ff;

endmodule

// file: cpu_irq_regs.vh
// Purpose: register offsets, field positions, reset values and cause codes
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   included by cpu_interrupt_acceptance.v
`ifndef CPU_IRQ_REGS_VH
`define CPU_IRQ_REGS_VH

// register byte offsets
`define CTRL_PAGE      4'h0
`define A_PSW          12'h100
`define A_IRQ_PC       12'h104
`define A_IRQ_ST       12'h108
`define A_NMI_PC       12'h10C
`define A_NMI_ST       12'h110
`define A_CAUSE        12'h114
`define A_INSVC        12'h118

// per-source control word fields
`define CTL_FLAG       7
`define CTL_MASK       6
`define CTL_PRI_HI     2
`define CTL_PRI_LO     0
`define CTL_RST_FLAG   1'h0
`define CTL_RST_MASK   1'h1
`define CTL_RST_PRI    3'h7

// state word flag positions and reset value
`define PSW_ID         5
`define PSW_EP         6
`define PSW_NP         7
`define PSW_RST        32'h0000_0020

// cause codes and vectors
`define NMI0_CODE      16'h0010
`define NMI1_CODE      16'h0020
`define NMI2_CODE      16'h0030
`define ILG_CODE       16'h0060
`define IRQ_BASE       16'h0080
`define IRQ_SHIFT      4
`define ILG_PC_STEP    32'h0000_0004

// non-maskable service level
`define NL_NONE        2'h0
`define NL_NMI0        2'h1
`define NL_NMI1        2'h2
`define NL_NMI2        2'h3

`endif

// file: irq_accept_sva.sv
// Purpose: concurrent checks on the interrupt acceptance ports
// Assumes: one pclk domain, async active-low presetn
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ns
module irq_accept_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  nonmask_request_pin,
    input wire logic        take_window,
    input wire logic        illegal_op,
    input wire logic        return_from_handler,
    input wire logic        redirect,
    input wire logic [31:0] redirect_pc,
    input wire logic [31:0] program_state_word
);
    logic ret_q;
    wire  irqv;
    ////////////////////////////////////////////////////////////////
    // last cycle's return, to tell entries from returns
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ret_q <= 1'b0;
        else
            ret_q <= return_from_handler;
    end
    // entry into a maskable vector
    assign irqv = redirect && !ret_q && redirect_pc >= 32'h0000_0080
                  && redirect_pc <= 32'h0000_0470 && redirect_pc[3:0] == 4'h0;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_APB_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ILG_VEC: assert property (illegal_op |=> redirect && redirect_pc == 32'h0000_0060)
        else $error("illegal opcode not vectored");
    AST_NMI2_TAKE: assert property ($rose(nonmask_request_pin[2]) ##1
        (take_window && !illegal_op && !return_from_handler) |=> redirect && redirect_pc == 32'h0000_0030)
        else $error("top request not taken");
    AST_NMI_ENTRY: assert property (redirect && !ret_q && (redirect_pc inside
        {32'h0000_0010, 32'h0000_0020, 32'h0000_0030}) |-> program_state_word[7:5] == 3'b101)
        else $error("bad state word on nmi entry");
    AST_IRQ_ENTRY: assert property (irqv |-> program_state_word[7:5] == 3'b001)
        else $error("bad state word on entry");
    AST_BLOCKED: assert property (program_state_word[5] && !return_from_handler |=> !irqv)
        else $error("entry while disabled");
    AST_RET_REDIR: assert property (return_from_handler && !illegal_op |=> redirect)
        else $error("return without redirect");
    AST_NMI_TOP: assert property (redirect && !ret_q && redirect_pc == 32'h0000_0030 |=>
        (!(redirect && (redirect_pc inside {32'h0000_0010, 32'h0000_0020})))[*8])
        else $error("lower request after top");
    COV_IRQ: cover property (irqv);
    COV_NMI: cover property (redirect && redirect_pc == 32'h0000_0030);
    COV_ERR: cover property (pready && pslverr);
endmodule

bind cpu_interrupt_acceptance irq_accept_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .nonmask_request_pin(nonmask_request_pin), .take_window(take_window),
    .illegal_op(illegal_op), .return_from_handler(return_from_handler), .redirect(redirect),
    .redirect_pc(redirect_pc), .program_state_word(program_state_word)
);

// file: pipe_model.sv
// Purpose: behavioural cpu pipeline facing the block
// Assumes: one instruction a cycle, four-byte steps
// Notes:   window opens at random so answers come promptly or late
`timescale 1ns/1ns
module pipe_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        redirect,
    input  wire logic [31:0] redirect_pc,
    output logic             take_window,
    output logic [31:0]      cur_pc,
    output logic [31:0]      following_pc,
    output logic             restart_cur
);
    ////////////////////////////////////////////////////////////////
    // step the pc, follow redirects, random window and restart
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            take_window  <= 1'b0;
            cur_pc       <= 32'h0000_1000;
            following_pc <= 32'h0000_1004;
            restart_cur  <= 1'b0;
        end
        else
        begin
            take_window <= ($urandom % 4) != 0;
            restart_cur <= 1'($urandom % 2);
            cur_pc      <= redirect ? redirect_pc : following_pc;
            following_pc <= (redirect ? redirect_pc : following_pc) + 32'h0000_0004;
        end
    end
endmodule

// file: cpu_interrupt_acceptance_tb_top.sv
// Purpose: self-checking bench for the interrupt acceptance block
// Assumes: pipeline partner in pipe_model, registers over apb
// Notes:   seeded random sources and levels plus fixed corner cases
`timescale 1ns/1ns
`include "cpu_irq_regs.vh"
module cpu_interrupt_acceptance_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, redirect, rerr;
    logic        illegal_op, return_from_handler, take_window, restart_cur, rst_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, redirect_pc, program_state_word, cur_pc, following_pc;
    logic [31:0] cpc_q, fpc_q, rd, ex, ex2, ix;
    logic [2:0]  nonmask_request_pin;
    logic [63:0] maskable_request_pin;
    int          failures, n_checks, n;
    ////////////////////////////////////////////////////////////////
    cpu_interrupt_acceptance u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nonmask_request_pin(nonmask_request_pin),
        .maskable_request_pin(maskable_request_pin), .take_window(take_window), .cur_pc(cur_pc),
        .following_pc(following_pc), .restart_cur(restart_cur), .illegal_op(illegal_op),
        .return_from_handler(return_from_handler), .redirect(redirect), .redirect_pc(redirect_pc),
        .program_state_word(program_state_word));
    pipe_model u_pipe (.pclk(pclk), .presetn(presetn), .redirect(redirect), .redirect_pc(redirect_pc),
        .take_window(take_window), .cur_pc(cur_pc), .following_pc(following_pc), .restart_cur(restart_cur));
    // clock and the pipeline state of the previous edge
    initial
    begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cpc_q <= cur_pc;
        fpc_q <= following_pc;
        rst_q <= restart_cur;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    // vector and cause code of maskable source k
    function automatic logic [31:0] irq_vec(input int k);
        return 32'(`IRQ_BASE) + (32'(k) << `IRQ_SHIFT);
    endfunction
    // one apb transfer, waiting for ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 40);
        rd = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        chk("apb ready", {31'b0, pready}, 1);
        @(posedge pclk);
    endtask
    // one-cycle pulse on pins, return or illegal opcode
    task ev(input logic [63:0] m, input logic [2:0] nm, input logic [1:0] ri);
        maskable_request_pin <= m;
        nonmask_request_pin <= nm;
        return_from_handler <= ri[0];
        illegal_op <= ri[1];
        @(posedge pclk);
        maskable_request_pin <= 0;
        nonmask_request_pin <= 0;
        return_from_handler <= 0;
        illegal_op <= 0;
    endtask
    // wait for a redirect and compare its target
    task wt(input string nm, input logic [31:0] x);
        int k;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (redirect !== 1'b1 && k < 40);
        chk(nm, {31'b0, redirect}, 1);
        chk(nm, redirect_pc, x);
        ex = rst_q ? cpc_q : fpc_q;
        ix = cpc_q + `ILG_PC_STEP;
    endtask
    task quiet(input int k);
        repeat (k)
        begin
            @(posedge pclk);
            chk("quiet", {31'b0, redirect}, 0);
        end
    endtask
    task do_reset;
        presetn <= 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
    endtask
    // enable every source at a random level, clear global disable
    task setup;
        for (int i = 0; i < 64; i++)
            apb(1, 12'(4 * i), {29'b0, 3'($urandom % 8)});
        apb(1, `A_PSW, 0);
    endtask
    task test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        test_done;
    end
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, illegal_op, return_from_handler} = 0;
        {paddr, pwdata, nonmask_request_pin, maskable_request_pin} = 0;
        void'($urandom(32'hbbd70d82));
        do_reset;
        chk("psw", program_state_word, `PSW_RST);
        apb(0, 12'h014, 0);
        chk("ctl", rd, 32'h0000_0047);
        apb(0, 12'h11C, 0);
        chk("unmapped", {31'b0, rerr}, 1);
        apb(1, `A_CAUSE, 32'h0000_0001);
        chk("readonly", {31'b0, rerr}, 1);
        $display("test reset done");
        ev(0, 3'b001, 0);
        wt("nmi0", 32'h0000_0010);
        ex2 = ex;
        chk("nmi psw", program_state_word[7:5], 3'b101);
        apb(0, `A_NMI_PC, 0);
        chk("nmi pc", rd, ex2);
        apb(0, `A_CAUSE, 0);
        chk("nmi cause", rd[31:16], `NMI0_CODE);
        ev(0, 3'b001, 0);
        quiet(6);
        ev(0, 0, 1);
        wt("nmi ret", ex2);
        wt("nmi0 held", 32'h0000_0010);
        ev(0, 3'b100, 0);
        wt("nmi2", 32'h0000_0030);
        do_reset;
        ev(0, 3'b001, 0);
        wt("nmi0", 32'h0000_0010);
        ev(0, 3'b010, 0);
        quiet(6);
        do_reset;
        ev(0, 3'b001, 0);
        wt("nmi0", 32'h0000_0010);
        apb(1, `A_PSW, `PSW_RST);
        ev(0, 3'b010, 0);
        wt("nmi1", 32'h0000_0020);
        do_reset;
        ev(0, 3'b111, 0);
        wt("nmi all", 32'h0000_0030);
        quiet(8);
        do_reset;
        $display("test nmi done");
        ev(0, 0, 2);
        wt("illegal", 32'h0000_0060);
        ex2 = ix;
        apb(0, `A_IRQ_PC, 0);
        chk("illegal pc", rd, ex2);
        do_reset;
        $display("test illegal done");
        setup;
        for (int i = 0; i < 8; i++)
        begin
            n = (i == 0) ? 63 : $urandom % 64;
            ev(64'h1 << n, 0, 0);
            wt("vector", irq_vec(n));
            ex2 = ex;
            chk("irq psw", program_state_word[7:5], 3'b001);
            apb(0, `A_CAUSE, 0);
            chk("irq cause", rd[15:0], irq_vec(n));
            apb(0, 12'(4 * n), 0);
            chk("flag", rd[7], 0);
            apb(0, `A_IRQ_PC, 0);
            chk("irq pc", rd, ex2);
            ev(0, 0, 1);
            wt("irq ret", ex2);
        end
        $display("test maskable done");
        apb(1, 12'h00C, 32'h0000_0002);
        apb(1, 12'h024, 32'h0000_0002);
        apb(1, 12'h01C, 32'h0000_0001);
        ev(64'h0000_0000_0000_0208, 0, 0);
        wt("tie", irq_vec(3));
        apb(0, `A_IRQ_PC, 0);
        ex2 = rd;
        apb(1, `A_PSW, 0);
        quiet(6);
        ev(64'h0000_0000_0000_0080, 0, 0);
        wt("nest", irq_vec(7));
        ev(0, 0, 1);
        wt("nest ret", ex);
        quiet(4);
        apb(1, `A_PSW, `PSW_RST);
        apb(1, `A_IRQ_PC, ex2);
        apb(1, `A_IRQ_ST, 0);
        ev(0, 0, 1);
        wt("outer ret", ex2);
        wt("held", irq_vec(9));
        $display("test nesting done");
        do_reset;
        setup;
        apb(1, 12'h010, 32'h0000_0040);
        ev(64'h0000_0000_0000_0010, 0, 0);
        quiet(6);
        apb(0, 12'h010, 0);
        chk("pending", rd[7], 1);
        apb(1, 12'h010, rd & 32'hffff_ffbf);
        wt("unmask", irq_vec(4));
        $display("test mask done");
        test_done;
    end
endmodule
